// ### verilog/cbmc_top.sv
// host controller sequencing cycles on the core buffer memory unit
// Overview of operation
// - random write uses address, strobes, data, trigger
// - sequential write sends count pulse instead
// - write trigger with kind line: clear/write
// - read trigger with kind line: read/restore
// - every control pulse lasts 0.5 to 1.0 us
// - single-ended inputs: clear latch 1 us before
// - strobes and count pulses no later than origin
// - levels stable 0.25 us before strobe
// - next strobe not before end minus 0.5 us
// - kind line set 0.5 us before, held 4 us
// - direction settled 4.5 us before count pulse
// - buffer clear after cycle end, then 25 us quiet
// - buffer clears 100 us apart, 40 per 10 ms
`timescale 1ns/1ps
`default_nettype none
module cbmc_top #(
  parameter int AW            = 10,  // address latch width, 7..10
  parameter int DW            = 24,  // word width, 4..24
  parameter int QUIET_CYCLES  = cbmc_pkg::QUIET_CYC,
  parameter int GAP_CYCLES    = cbmc_pkg::BCLR_GAP_CYC,
  parameter int WINDOW_CYCLES = cbmc_pkg::BCLR_WIN_CYC
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite slave
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // unit pins
  output logic [AW-1:0]      addr_level,
  output logic               addr_strobe,
  output logic               addr_clear,
  output logic [DW-1:0]      data_level,
  output logic               info_strobe,
  output logic               word_clear,
  output logic               write_trigger,
  output logic               read_trigger,
  output logic               cycle_kind_select,
  output logic               buffer_clear,
  output logic               dir_forward,
  output logic               dir_reverse,
  output logic               count_pulse,
  output logic               swap_pulse,
  input  wire logic [AW-1:0] addr_out,
  input  wire logic [DW-1:0] data_out,
  input  wire logic [1:0]    unit_state_lines
);
  import cbmc_pkg::*;
  cbmc_cmd_if cmd ();
  logic [AW-1:0] addr_s;
  logic [DW-1:0] data_s;
  logic [1:0]    ust_s;
  // pins from the unit are asynchronous to aclk
  cbmc_sync3 #(.W(AW + DW + 2)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({addr_out, data_out, unit_state_lines}),
    .q       ({addr_s, data_s, ust_s})
  );
  // axi4-lite slave
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg, ctrl_reg, addr_reg, wd_reg, wmask;
  logic [3:0]  wstrb_reg;
  logic        aw_held_reg, w_held_reg, go_reg, wr_do, wr_err;
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_do         = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // hold address and data until both have arrived, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held_reg <= 1'b0;
      end
    end
  end
  // byte-lane mask for writable registers
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  always_comb begin
    if (awaddr_reg == OFS_CTRL || awaddr_reg == OFS_ADDR || awaddr_reg == OFS_WDATA) begin
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end
  // register writes; go pulses one cycle when ctrl bit 0 written to 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= 32'h0000_0000;
      addr_reg     <= 32'h0000_0000;
      wd_reg       <= 32'h0000_0000;
      go_reg       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      go_reg <= 1'b0;
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
        if (awaddr_reg == OFS_CTRL) begin
          ctrl_reg <= ((ctrl_reg & ~wmask) | (wdata_reg & wmask)) & 32'h0000_01FE;
          go_reg   <= wstrb_reg[0] && wdata_reg[CF_GO];
        end else if (awaddr_reg == OFS_ADDR) begin
          addr_reg <= (addr_reg & ~wmask) | (wdata_reg & wmask);
        end else if (awaddr_reg == OFS_WDATA) begin
          wd_reg <= (wd_reg & ~wmask) | (wdata_reg & wmask);
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  // reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == OFS_CTRL) begin
        s_axi_rdata <= ctrl_reg;
      end else if (s_axi_araddr == OFS_ADDR) begin
        s_axi_rdata <= addr_reg;
      end else if (s_axi_araddr == OFS_WDATA) begin
        s_axi_rdata <= wd_reg;
      end else if (s_axi_araddr == OFS_STATUS) begin
        s_axi_rdata <= cmd.status;
      end else if (s_axi_araddr == OFS_RADDR) begin
        s_axi_rdata <= cmd.raddr;
      end else if (s_axi_araddr == OFS_RDATA) begin
        s_axi_rdata <= cmd.rdata;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign cmd.go    = go_reg;
  assign cmd.ctrl  = ctrl_reg;
  assign cmd.addr  = addr_reg;
  assign cmd.wdata = wd_reg;
  // cycle sequencer
  cbmc_state_t   state_reg;
  logic [23:0]   cnt_reg;          // cycles left in current phase
  logic [23:0]   since_reg;        // cycles since last direction or kind change
  logic [23:0]   gap_reg, win_reg; // since last buffer clear; budget window
  logic [5:0]    nclr_reg;         // clears in current window
  cbmc_op_t      op_reg, op_in;
  logic          mem_reg, seq_reg, refused_reg, done_reg, dir_chg, start_ok, both_dir;
  logic [AW-1:0] raddr_reg;
  logic [DW-1:0] rdata_reg;
  assign op_in    = cbmc_op_t'(cmd.ctrl[CF_OP_LO +: 3]);
  assign both_dir = cmd.ctrl[CF_FWD] && cmd.ctrl[CF_REV];
  assign dir_chg  = (cmd.ctrl[CF_FWD] != dir_forward) || (cmd.ctrl[CF_REV] != dir_reverse)
                    || (cmd.ctrl[CF_KIND] != cycle_kind_select);
  // a buffer clear needs spacing and budget; counting or swap is refused with both directions set
  always_comb begin
    start_ok = 1'b1;
    if (op_in == CBMC_OP_BCLR) begin
      start_ok = (gap_reg >= 24'(GAP_CYCLES)) && (nclr_reg < 6'(BCLR_MAX));
    end else if (both_dir && (cmd.ctrl[CF_SEQ] || op_in == CBMC_OP_SWAP)) begin
      start_ok = 1'b0;
    end
  end

  // kind and direction levels follow ctrl only while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_forward       <= 1'b0;
      dir_reverse       <= 1'b0;
      cycle_kind_select <= 1'b0;
      since_reg         <= 24'h00_0000;
    end else if (state_reg == CBMC_IDLE && dir_chg) begin
      dir_forward       <= cmd.ctrl[CF_FWD];
      dir_reverse       <= cmd.ctrl[CF_REV];
      cycle_kind_select <= cmd.ctrl[CF_KIND];
      since_reg         <= 24'h00_0000;
    end else if (since_reg != 24'hFF_FFFF) begin
      since_reg <= since_reg + 24'h00_0001;
    end
  end

  // main sequence: preclear, setup, pulse at origin, then cycle, or quiet for a buffer clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= CBMC_IDLE;
      cnt_reg     <= 24'h00_0000;
      op_reg      <= CBMC_OP_WRITE;
      mem_reg     <= 1'b0;
      seq_reg     <= 1'b0;
      refused_reg <= 1'b0;
      done_reg    <= 1'b0;
      addr_level  <= '0;
      data_level  <= '0;
    end else begin
      if (cnt_reg != 24'h00_0000) begin
        cnt_reg <= cnt_reg - 24'h00_0001;
      end
      case (state_reg)
        CBMC_IDLE: begin
          if (cmd.go) begin
            if (!start_ok) begin
              refused_reg <= 1'b1;
            end else begin
              refused_reg <= 1'b0;
              done_reg    <= 1'b0;
              op_reg      <= op_in;
              mem_reg     <= cmd.ctrl[CF_KIND];
              seq_reg     <= cmd.ctrl[CF_SEQ];
              addr_level  <= cmd.addr[AW-1:0];
              data_level  <= cmd.wdata[DW-1:0];
              if (cmd.ctrl[CF_SINGLE]) begin
                state_reg <= CBMC_PRECLR;
                cnt_reg   <= 24'(PRECLR_CYC);
              end else begin
                state_reg <= CBMC_SETUP;
                cnt_reg   <= 24'(SETUP_CYC);
              end
            end
          end
        end
        CBMC_PRECLR: begin
          if (cnt_reg <= 24'h00_0001) begin
            state_reg <= CBMC_SETUP;
            cnt_reg   <= 24'(SETUP_CYC);
          end
        end
        CBMC_SETUP: begin
          // hold until levels, kind line and direction have settled
          if (cnt_reg <= 24'h00_0001 && since_reg >= 24'(DIR_SU_CYC)) begin
            state_reg <= CBMC_PULSE;
            cnt_reg   <= 24'(PULSE_CYC);
          end
        end
        CBMC_PULSE: begin
          if (cnt_reg <= 24'h00_0001 && op_reg == CBMC_OP_BCLR) begin
            state_reg <= CBMC_QUIET;
            cnt_reg   <= 24'(QUIET_CYCLES);
          end else if (cnt_reg <= 24'h00_0001) begin
            state_reg <= CBMC_CYCLE;
            // cycle counted from origin, pulse time already spent
            cnt_reg   <= 24'((mem_reg ? MEM_CYC : BUF_CYC) - PULSE_CYC);
          end
        end
        CBMC_CYCLE: begin
          // outputs taken 4 us after origin plus the synchroniser lag
          if (cnt_reg == 24'((mem_reg ? MEM_CYC : BUF_CYC) - DVALID_CYC - SYNC_LAG)) begin
            rdata_reg <= data_s;
            raddr_reg <= addr_s;
          end
          if (cnt_reg <= 24'h00_0001) begin
            state_reg <= CBMC_IDLE;
            done_reg  <= 1'b1;
          end
        end
        CBMC_QUIET: begin
          if (cnt_reg <= 24'h00_0001) begin
            state_reg <= CBMC_IDLE;
            done_reg  <= 1'b1;
          end
        end
        default: state_reg <= CBMC_IDLE;
      endcase
    end
  end

  // buffer clear spacing and per-window budget
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg  <= 24'(GAP_CYCLES);
      win_reg  <= 24'h00_0000;
      nclr_reg <= 6'h00;
    end else begin
      if (state_reg == CBMC_PULSE && op_reg == CBMC_OP_BCLR && cnt_reg == 24'(PULSE_CYC)) begin
        gap_reg <= 24'h00_0000;
      end else if (gap_reg < 24'(GAP_CYCLES)) begin
        gap_reg <= gap_reg + 24'h00_0001;
      end
      // fixed windows are looser than a sliding one if clears bunch at an edge
      if (win_reg >= 24'(WINDOW_CYCLES - 1)) begin
        win_reg  <= 24'h00_0000;
        nclr_reg <= 6'h00;
      end else begin
        win_reg <= win_reg + 24'h00_0001;
        if (state_reg == CBMC_PULSE && op_reg == CBMC_OP_BCLR && cnt_reg == 24'(PULSE_CYC)) begin
          nclr_reg <= nclr_reg + 6'h01;
        end
      end
    end
  end

  // pulse pins, active during PULSE except the two clears, which are active during PRECLR (word_clear for writes only)
  logic pulsing;
  assign pulsing       = (state_reg == CBMC_PULSE);
  assign addr_clear    = (state_reg == CBMC_PRECLR);
  assign word_clear    = (state_reg == CBMC_PRECLR) && (op_reg == CBMC_OP_WRITE);
  assign write_trigger = pulsing && (op_reg == CBMC_OP_WRITE);
  assign read_trigger  = pulsing && (op_reg == CBMC_OP_READ);
  assign addr_strobe   = pulsing && !seq_reg
                         && (op_reg == CBMC_OP_WRITE || op_reg == CBMC_OP_READ);
  assign info_strobe   = pulsing && (op_reg == CBMC_OP_WRITE);
  assign count_pulse   = pulsing && seq_reg
                         && (op_reg == CBMC_OP_WRITE || op_reg == CBMC_OP_READ);
  assign swap_pulse    = pulsing && (op_reg == CBMC_OP_SWAP);
  assign buffer_clear  = pulsing && (op_reg == CBMC_OP_BCLR);

  assign cmd.busy    = (state_reg != CBMC_IDLE);
  assign cmd.refused = refused_reg;
  assign cmd.status  = {24'h00_0000, 2'b00, ust_s, refused_reg, done_reg,
                        nclr_reg == 6'(BCLR_MAX), cmd.busy};
  assign cmd.raddr   = 32'(raddr_reg);
  assign cmd.rdata   = 32'(rdata_reg);
endmodule
`default_nettype wire

// ### verilog/cbmc_pkg.sv
// shared constants and types for the core buffer memory cycle controller
package cbmc_pkg;
  // cycle counts at 20 MHz from nanosecond figures; least times round up
  localparam int CLK_NS       = 50;
  localparam int RU           = CLK_NS - 1;
  localparam int PULSE_CYC    = 750 / CLK_NS;          // inside the 0.5..1.0 us window
  localparam int SETUP_CYC    = (250 + RU) / CLK_NS;   // levels before strobe
  localparam int PRECLR_CYC   = (1000 + RU) / CLK_NS;  // latch clear ahead of transfer
  localparam int MODE_SU_CYC  = (500 + RU) / CLK_NS;   // cycle kind ahead of origin
  localparam int MODE_HD_CYC  = (4000 + RU) / CLK_NS;  // cycle kind held after origin
  localparam int DIR_SU_CYC   = (4500 + RU) / CLK_NS;  // direction ahead of count pulse
  localparam int BUF_CYC      = (5000 + RU) / CLK_NS;
  localparam int MEM_CYC      = (8000 + RU) / CLK_NS;
  localparam int DVALID_CYC   = (4000 + RU) / CLK_NS;
  localparam int SYNC_LAG     = 4;                     // three-flop input path plus output flop
  localparam int QUIET_CYC    = (25000 + RU) / CLK_NS;
  localparam int BCLR_GAP_CYC = (100000 + RU) / CLK_NS;
  localparam int BCLR_WIN_CYC = (10000000 + RU) / CLK_NS;
  localparam int BCLR_MAX     = 40;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_RADDR  = 8'h10;
  localparam logic [7:0] OFS_RDATA  = 8'h14;
  // control word fields
  localparam int CF_GO     = 0;   // write 1 starts the operation
  localparam int CF_OP_LO  = 1;   // 3-bit operation code
  localparam int CF_KIND   = 4;   // cycle_kind_select level
  localparam int CF_FWD    = 5;
  localparam int CF_REV    = 6;
  localparam int CF_SEQ    = 7;   // count pulse instead of address strobe
  localparam int CF_SINGLE = 8;   // single-ended inputs: pre-clear latches
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    CBMC_OP_WRITE = 3'h0, CBMC_OP_READ = 3'h1, CBMC_OP_SWAP = 3'h2,
    CBMC_OP_BCLR = 3'h3
  } cbmc_op_t;
  // gray codes along idle, preclear, setup, pulse, cycle, quiet
  typedef enum logic [2:0] {
    CBMC_IDLE = 3'b000, CBMC_PRECLR = 3'b001, CBMC_SETUP = 3'b011,
    CBMC_PULSE = 3'b010, CBMC_CYCLE = 3'b110, CBMC_QUIET = 3'b111
  } cbmc_state_t;
endpackage

// ### verilog/cbmc_cmd_if.sv
// command and status carrier between bus slave and sequencer
`timescale 1ns/1ps
`default_nettype none
interface cbmc_cmd_if;
  import cbmc_pkg::*;
  logic        go;
  logic [31:0] ctrl;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic        busy;
  logic        refused;
  logic [31:0] status;
  logic [31:0] raddr;
  logic [31:0] rdata;
  modport bus (output go, ctrl, addr, wdata, input busy, refused, status, raddr, rdata);
  modport seq (input go, ctrl, addr, wdata, output busy, refused, status, raddr, rdata);
endinterface
`default_nettype wire

// ### verilog/cbmc_sync3.sv
// three-stage input synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cbmc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // s1 feeds only s2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/cbmc_top_assertions.sv
// timing checks on the unit-side pins of the cycle controller
`timescale 1ns/1ps
`default_nettype none
module cbmc_top_assertions #(
  parameter int AW           = 10,
  parameter int QUIET_CYCLES = 4,
  parameter int GAP_CYCLES   = 50
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] addr_level,
  input  wire logic          addr_strobe,
  input  wire logic          write_trigger,
  input  wire logic          read_trigger,
  input  wire logic          cycle_kind_select,
  input  wire logic          buffer_clear,
  input  wire logic          dir_forward,
  input  wire logic          dir_reverse,
  input  wire logic          count_pulse,
  input  wire logic          swap_pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam int SAT = 100000;
  logic       trg, pls, trg_d, bc_d, kd, mem_l;
  logic [1:0] dd;
  int         pl, org, bc, ka, da;
  assign trg = write_trigger | read_trigger;
  assign pls = trg | count_pulse | swap_pulse | buffer_clear | addr_strobe;
  // ages saturate so long idle spells never wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {trg_d, bc_d, kd, mem_l, dd} <= '0;
      pl <= 0;
      {org, bc, ka, da} <= {SAT, SAT, SAT, SAT};
    end else begin
      {trg_d, bc_d, kd, dd} <= {trg, buffer_clear, cycle_kind_select, dir_forward, dir_reverse};
      pl  <= pls ? pl + 1 : 0;
      org <= (trg && !trg_d) ? 1 : (org < SAT ? org + 1 : org);
      bc  <= (buffer_clear && !bc_d) ? 1 : (bc < SAT ? bc + 1 : bc);
      ka  <= (cycle_kind_select != kd) ? 0 : (ka < SAT ? ka + 1 : ka);
      da  <= ({dir_forward, dir_reverse} != dd) ? 0 : (da < SAT ? da + 1 : da);
      if (trg && !trg_d) mem_l <= cycle_kind_select;
    end
  end
  property p_pulse_min; $fell(pls) |-> pl >= 10; endproperty
  a_pulse_min: assert property (p_pulse_min)
    else $error("control pulse too short");
  property p_pulse_max; pls |-> pl < 20; endproperty
  a_pulse_max: assert property (p_pulse_max)
    else $error("control pulse too long");
  property p_strobe_by_origin; $rose(trg) |-> addr_strobe || count_pulse || swap_pulse; endproperty
  a_strobe_by_origin: assert property (p_strobe_by_origin)
    else $error("no strobe at cycle origin");
  property p_lvl_setup; $rose(addr_strobe) |-> $past(addr_level, 5) == addr_level; endproperty
  a_lvl_setup: assert property (p_lvl_setup)
    else $error("address level moved before strobe");
  property p_kind_setup; $rose(trg) |-> ka >= 9; endproperty
  a_kind_setup: assert property (p_kind_setup)
    else $error("cycle kind set too late");
  property p_kind_hold; $changed(cycle_kind_select) |-> org >= 80; endproperty
  a_kind_hold: assert property (p_kind_hold)
    else $error("cycle kind released too early");
  property p_dir_setup; $rose(count_pulse) || $rose(swap_pulse) |-> da >= 89; endproperty
  a_dir_setup: assert property (p_dir_setup)
    else $error("direction changed too close to count");
  property p_cyc_end; $rose(trg) |-> org >= (mem_l ? 160 : 100) && bc >= QUIET_CYCLES + 15; endproperty
  a_cyc_end: assert property (p_cyc_end)
    else $error("trigger before cycle end");
  property p_clr_end; $rose(buffer_clear) |-> org >= (mem_l ? 160 : 100); endproperty
  a_clr_end: assert property (p_clr_end)
    else $error("buffer clear inside cycle");
  property p_clr_gap; $rose(buffer_clear) |-> bc >= GAP_CYCLES; endproperty
  a_clr_gap: assert property (p_clr_gap)
    else $error("buffer clears too close");
  property p_both_dirs; count_pulse || swap_pulse |-> !(dir_forward && dir_reverse); endproperty
  a_both_dirs: assert property (p_both_dirs)
    else $error("count with both directions");
  c_mem_cycle: cover property ($rose(trg) && cycle_kind_select);
  c_count: cover property ($rose(count_pulse));
  c_clear: cover property ($rose(buffer_clear));
endmodule
bind cbmc_top cbmc_top_assertions #(.AW(AW), .QUIET_CYCLES(QUIET_CYCLES),
  .GAP_CYCLES(GAP_CYCLES)) u_chk (.*);
`default_nettype wire

// ### verif/cbmc_unit_model.sv
// behavioural model of the buffer memory unit behind the controller
`timescale 1ns/1ps
`default_nettype none
module cbmc_unit_model #(
  parameter int AW = 10,
  parameter int DW = 24
) (
  input  wire logic [AW-1:0] addr_level,
  input  wire logic          addr_strobe,
  input  wire logic          addr_clear,
  input  wire logic [DW-1:0] data_level,
  input  wire logic          info_strobe,
  input  wire logic          word_clear,
  input  wire logic          write_trigger,
  input  wire logic          read_trigger,
  input  wire logic          cycle_kind_select,
  input  wire logic          buffer_clear,
  input  wire logic          dir_forward,
  input  wire logic          dir_reverse,
  input  wire logic          count_pulse,
  input  wire logic          swap_pulse,
  output logic [AW-1:0]      addr_out,
  output logic [DW-1:0]      data_out,
  output logic [1:0]         unit_state_lines
);
  logic [AW-1:0] ar = '0, sv = '0;
  logic [DW-1:0] mr = '0;
  logic [DW-1:0] mem [2**AW];
  logic          av = 1'b1, dv = 1'b1;
  logic [1:0]    st = 2'b00;
  // binary radix; both lines energised holds still rather than guess
  function automatic logic [AW-1:0] step(input logic [AW-1:0] a);
    if (dir_forward && !dir_reverse) return a + 1'b1;
    if (dir_reverse && !dir_forward) return a - 1'b1;
    return a;
  endfunction
  // latch loads happen at the strobe edge
  initial foreach (mem[i]) mem[i] = '0;
  always @(posedge addr_clear) ar = '0;
  always @(posedge word_clear) mr = '0;
  always @(posedge addr_strobe) ar = addr_level;
  always @(posedge info_strobe) mr = data_level;
  always @(posedge count_pulse) ar = step(ar);
  always @(posedge swap_pulse) {ar, sv} = {sv, step(ar)};
  always @(posedge buffer_clear) foreach (mem[i]) mem[i] = '0;
  // latches settle 1 ns before the cycle; outputs inverted until valid
  always @(posedge write_trigger) begin
    #1;
    mem[ar] = mr;
    {av, dv} = 2'b00;
    st = {cycle_kind_select, 1'b1};
    #1000 av = 1'b1;
    #500 dv = 1'b1;
    #(st[1] ? 6499 : 3499) st = 2'b00;
  end
  always @(posedge read_trigger) begin
    #1;
    {av, dv} = 2'b00;
    st = {cycle_kind_select, 1'b1};
    mr = mem[ar];
    if (!cycle_kind_select) mem[ar] = '0;
    #1000 av = 1'b1;
    #2500 dv = 1'b1;
    #(st[1] ? 4499 : 1499) st = 2'b00;
  end
  assign addr_out = av ? ar : ~ar;
  assign data_out = dv ? mr : ~mr;
  assign unit_state_lines = st;
endmodule
`default_nettype wire

// ### verif/cbmc_top_tb.sv
// self-checking bench: controller driving the unit model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module cbmc_top_tb;
  import cbmc_pkg::*;
  localparam logic [31:0] FK = 32'h1 << CF_KIND, FF = 32'h1 << CF_FWD, FR = 32'h1 << CF_REV;
  localparam logic [31:0] FS = 32'h1 << CF_SEQ, FSE = 32'h1 << CF_SINGLE;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v, st;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, unit_state_lines, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [9:0]  addr_level, addr_out;
  logic [23:0] data_level, data_out;
  logic        addr_strobe, addr_clear, info_strobe, word_clear, write_trigger;
  logic        read_trigger, cycle_kind_select, buffer_clear, dir_forward;
  logic        dir_reverse, count_pulse, swap_pulse;
  int          failures = 0, checks_done = 0;
  cbmc_top #(.QUIET_CYCLES(4), .GAP_CYCLES(400), .WINDOW_CYCLES(20000)) dut (.*);
  cbmc_unit_model u_unit (.*);
  // 20 MHz clock
  always #25 aclk = ~aclk;
  // bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {d, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // start an operation and poll busy; the watchdog bounds a stuck unit
  task automatic op(input logic [2:0] o, input logic [31:0] fl, output logic [31:0] s);
    logic [1:0] rs;
    wr(OFS_CTRL, fl | 32'({o, 1'b1}), rs);
    do rd(OFS_STATUS, s, rs); while (s[0] !== 1'b0);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_STATUS, st, r);
    `CHK("idle busy", 1'b0, st[0])
    rd(8'h20, v, r);
    `CHK("unmapped rresp", RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h0, v)
    wr(8'h24, 32'h1, r);
    `CHK("unmapped bresp", RESP_SLVERR, r)
    $display("test reset done");
    wr(OFS_ADDR, 32'h5, r);
    wr(OFS_WDATA, 32'hABCDE5, r);
    op(CBMC_OP_WRITE, FSE, st);
    `CHK("word 5", 24'hABCDE5, u_unit.mem[5])
    rd(OFS_RADDR, v, r);
    `CHK("raddr", 32'h5, v)
    rd(OFS_RDATA, v, r);
    `CHK("written word", 32'hABCDE5, v)
    op(CBMC_OP_READ, 32'h0, st);
    rd(OFS_RDATA, v, r);
    `CHK("read word", 32'hABCDE5, v)
    `CHK("destroyed", 24'h0, u_unit.mem[5])
    $display("test buffer done");
    wr(OFS_ADDR, 32'h7, r);
    wr(OFS_WDATA, 32'h123456, r);
    op(CBMC_OP_WRITE, FK, st);
    `CHK("clear write", 24'h123456, u_unit.mem[7])
    op(CBMC_OP_READ, FK, st);
    rd(OFS_RDATA, v, r);
    `CHK("restore read", 32'h123456, v)
    `CHK("restored", 24'h123456, u_unit.mem[7])
    $display("test memory done");
    wr(OFS_WDATA, 32'hA, r);
    op(CBMC_OP_WRITE, FS | FF, st);
    `CHK("count up", 10'h8, u_unit.ar)
    `CHK("seq word", 24'hA, u_unit.mem[8])
    op(CBMC_OP_READ, FS | FR, st);
    rd(OFS_RADDR, v, r);
    `CHK("count down", 32'h7, v)
    op(CBMC_OP_SWAP, FF, st);
    `CHK("swap addr", 10'h0, u_unit.ar)
    `CHK("swap saved", 10'h8, u_unit.sv)
    op(CBMC_OP_SWAP, 32'h0, st);
    `CHK("plain swap", 10'h8, u_unit.ar)
    op(CBMC_OP_WRITE, FS | FF | FR, st);
    `CHK("both refused", 1'b1, st[3])
    `CHK("no step", 10'h8, u_unit.ar)
    $display("test count done");
    op(CBMC_OP_BCLR, 32'h0, st);
    `CHK("buffer cleared", 24'h0, u_unit.mem[8])
    op(CBMC_OP_BCLR, 32'h0, st);
    `CHK("gap refused", 1'b1, st[3])
    $display("test clear done");
    stop_test();
  end
  // about 2000 cycles expected; a hang runs into this
  initial begin
    repeat (30000) @(posedge aclk);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
